// ---- design/fob_defs.vh ----
// fast overcurrent blanking: register map, field positions and timing constants
// assumes a 20 MHz controller clock; included by the design files by bare name
`ifndef FOB_DEFS_VH
`define FOB_DEFS_VH

// clock period in ns
`define FOB_CLK_NS 50
// least time in ns to whole cycles, rounded up, never below one
`define FOB_CYC(ns) ((((ns) + `FOB_CLK_NS - 1) / `FOB_CLK_NS) < 1 ? 1 : (((ns) + `FOB_CLK_NS - 1) / `FOB_CLK_NS))

// register offsets
`define FOB_ADDR_GAIN   16'hfe3c
`define FOB_ADDR_TIMING 16'hfe3d

// gain scale fields
`define FOB_GAIN_EXP_HI  15
`define FOB_GAIN_EXP_LO  11
`define FOB_GAIN_MAN_HI  9
`define FOB_GAIN_MAN_LO  0
`define FOB_GAIN_RESET   16'h0000

// timing fields
`define FOB_DEB_HI        4
`define FOB_DEB_LO        3
`define FOB_BLANK_HI      2
`define FOB_BLANK_LO      0
`define FOB_TIMING_RESET  8'h00

// threshold code fields handed on to the comparator
`define FOB_LIM_LEVEL_HI  1
`define FOB_LIM_LEVEL_LO  0
`define FOB_LIM_NEG       2

// debounce times in ns
`define FOB_DEB0_NS 40
`define FOB_DEB1_NS 80
`define FOB_DEB2_NS 120
`define FOB_DEB3_NS 240

// blanking times in ns
`define FOB_BLK0_NS 40
`define FOB_BLK1_NS 80
`define FOB_BLK2_NS 120
`define FOB_BLK3_NS 160
`define FOB_BLK4_NS 200
`define FOB_BLK5_NS 400
`define FOB_BLK6_NS 600
`define FOB_BLK7_NS 800

// timer width, enough for the longest blanking count
`define FOB_CNT_W 5

`endif

// ---- design/fob_regs.v ----
// fast overcurrent blanking: the two software registers
// assumes a simple same-clock access port; reads answer one cycle later
`timescale 1ns/1ps
`include "fob_defs.vh"

module fob_regs (
	input  wire        clock,
	input  wire        srst,
	input  wire [15:0] reg_addr,
	input  wire        reg_wr_en,
	input  wire [15:0] reg_wdata,
	input  wire        reg_rd_en,
	output reg  [15:0] reg_rdata,
	output reg  [15:0] gain_reg,
	output reg  [7:0]  timing_reg
);

	// writes store only the writable fields; reserved bits stay zero
	always @(posedge clock)
	begin
		if (srst)
		begin
			gain_reg   <= `FOB_GAIN_RESET;
			timing_reg <= `FOB_TIMING_RESET;
		end
		else if (reg_wr_en)
		begin
			if (reg_addr == `FOB_ADDR_GAIN)
			begin
				gain_reg[`FOB_GAIN_EXP_HI:`FOB_GAIN_EXP_LO] <= reg_wdata[`FOB_GAIN_EXP_HI:`FOB_GAIN_EXP_LO];
				gain_reg[`FOB_GAIN_MAN_HI:`FOB_GAIN_MAN_LO] <= reg_wdata[`FOB_GAIN_MAN_HI:`FOB_GAIN_MAN_LO];
			end
			if (reg_addr == `FOB_ADDR_TIMING)
			begin
				timing_reg[`FOB_DEB_HI:`FOB_DEB_LO]     <= reg_wdata[`FOB_DEB_HI:`FOB_DEB_LO];
				timing_reg[`FOB_BLANK_HI:`FOB_BLANK_LO] <= reg_wdata[`FOB_BLANK_HI:`FOB_BLANK_LO];
			end
		end
	end

	// read data is held until the next read; unmapped offsets read zero
	always @(posedge clock)
	begin
		if (srst)
			reg_rdata <= 16'h0000;
		else if (reg_rd_en)
		begin
			case (reg_addr)
				`FOB_ADDR_GAIN:   reg_rdata <= gain_reg;
				`FOB_ADDR_TIMING: reg_rdata <= {8'h00, timing_reg};
				default:          reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

// ---- design/fob_top.v ----
// fast overcurrent blanking: blanking, debounce and pwm cutoff, plus the gain scale register
// assumes pwm_in, pwm_on_edge and cycle_start come from the pwm generator on the same clock;
// the comparator output is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "fob_defs.vh"

// Operation
// - gain register bits 15:11 hold a writable two's-complement exponent
// - gain bits 9:0 hold mantissa; bit 10 reads zero; gain = mantissa times 2^exponent
// - overcurrent declared only after the sense stays above threshold the whole debounce time
// - debounce field bits 4:3 select 40, 80, 120 or 240 ns
// - after debounce all pwm outputs are forced off until the switching cycle ends
// - during blanking the comparator is ignored: no debounce counting, no cutoff
// - blanking field bits 2:0 select 40 to 800 ns; bits 7:5 read zero
// - the comparator threshold comes from a separate 3-bit field, top bit sets polarity
module fob_top #(
	parameter PWM_N = 2
) (
	input  wire             clock,
	input  wire             srst,
	input  wire [15:0]      reg_addr,
	input  wire             reg_wr_en,
	input  wire [15:0]      reg_wdata,
	input  wire             reg_rd_en,
	output wire [15:0]      reg_rdata,
	input  wire             overcurrent_cmp,
	input  wire [2:0]       current_limit_threshold,
	input  wire [PWM_N-1:0] pwm_in,
	input  wire             pwm_on_edge,
	input  wire             cycle_start,
	output reg  [PWM_N-1:0] pwm_out,
	output reg  [1:0]       limit_level,
	output reg              limit_negative,
	output reg              overcurrent_event,
	output reg              overcurrent_shutdown,
	output wire [15:0]      input_current_gain_scale
);

	wire [15:0]          gain_reg;
	wire [7:0]           timing_reg;
	reg                  cmp_meta_reg;
	reg                  cmp_sync_reg;
	reg [`FOB_CNT_W-1:0] blank_cnt_reg;
	reg [`FOB_CNT_W-1:0] blank_cnt_next;
	reg [`FOB_CNT_W-1:0] deb_cnt_reg;
	reg [`FOB_CNT_W-1:0] deb_cnt_next;
	reg                  shutdown_next;
	wire                 blanking;
	wire                 trip;
	wire                 cmp_live;
	wire                 deb_full;
	wire [`FOB_CNT_W-1:0] deb_cycles;
	wire [`FOB_CNT_W-1:0] blank_cycles;

	// whole-cycle counts of the programmed times, cut to the timer width where they are used;
	// five bits hold the longest count, sixteen cycles of blanking
	localparam integer          DEB0_CYC = `FOB_CYC(`FOB_DEB0_NS);
	localparam integer          DEB1_CYC = `FOB_CYC(`FOB_DEB1_NS);
	localparam integer          DEB2_CYC = `FOB_CYC(`FOB_DEB2_NS);
	localparam integer          DEB3_CYC = `FOB_CYC(`FOB_DEB3_NS);
	localparam integer          BLK0_CYC = `FOB_CYC(`FOB_BLK0_NS);
	localparam integer          BLK1_CYC = `FOB_CYC(`FOB_BLK1_NS);
	localparam integer          BLK2_CYC = `FOB_CYC(`FOB_BLK2_NS);
	localparam integer          BLK3_CYC = `FOB_CYC(`FOB_BLK3_NS);
	localparam integer          BLK4_CYC = `FOB_CYC(`FOB_BLK4_NS);
	localparam integer          BLK5_CYC = `FOB_CYC(`FOB_BLK5_NS);
	localparam integer          BLK6_CYC = `FOB_CYC(`FOB_BLK6_NS);
	localparam integer          BLK7_CYC = `FOB_CYC(`FOB_BLK7_NS);
	localparam [`FOB_CNT_W-1:0] CNT_ZERO = {`FOB_CNT_W{1'b0}};
	localparam [`FOB_CNT_W-1:0] CNT_ONE  = {{(`FOB_CNT_W-1){1'b0}}, 1'b1};

	// debounce code to a cycle count
	function [`FOB_CNT_W-1:0] deb_lookup;
		input [1:0] code;
		begin
			case (code)
				2'h0:    deb_lookup = DEB0_CYC[`FOB_CNT_W-1:0];
				2'h1:    deb_lookup = DEB1_CYC[`FOB_CNT_W-1:0];
				2'h2:    deb_lookup = DEB2_CYC[`FOB_CNT_W-1:0];
				default: deb_lookup = DEB3_CYC[`FOB_CNT_W-1:0];
			endcase
		end
	endfunction

	// blanking code to a cycle count
	function [`FOB_CNT_W-1:0] blank_lookup;
		input [2:0] code;
		begin
			case (code)
				3'h0:    blank_lookup = BLK0_CYC[`FOB_CNT_W-1:0];
				3'h1:    blank_lookup = BLK1_CYC[`FOB_CNT_W-1:0];
				3'h2:    blank_lookup = BLK2_CYC[`FOB_CNT_W-1:0];
				3'h3:    blank_lookup = BLK3_CYC[`FOB_CNT_W-1:0];
				3'h4:    blank_lookup = BLK4_CYC[`FOB_CNT_W-1:0];
				3'h5:    blank_lookup = BLK5_CYC[`FOB_CNT_W-1:0];
				3'h6:    blank_lookup = BLK6_CYC[`FOB_CNT_W-1:0];
				default: blank_lookup = BLK7_CYC[`FOB_CNT_W-1:0];
			endcase
		end
	endfunction

	// software registers
	fob_regs u_regs (
		.clock      (clock),
		.srst       (srst),
		.reg_addr   (reg_addr),
		.reg_wr_en  (reg_wr_en),
		.reg_wdata  (reg_wdata),
		.reg_rd_en  (reg_rd_en),
		.reg_rdata  (reg_rdata),
		.gain_reg   (gain_reg),
		.timing_reg (timing_reg)
	);

	// metering sees the stored gain word straight from its flip-flops
	assign input_current_gain_scale = gain_reg;

	assign deb_cycles   = deb_lookup(timing_reg[`FOB_DEB_HI:`FOB_DEB_LO]);
	assign blank_cycles = blank_lookup(timing_reg[`FOB_BLANK_HI:`FOB_BLANK_LO]);

	// comparator comes straight off an analog pin, so two flops before any use
	always @(posedge clock)
	begin
		if (srst)
		begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end
		else
		begin
			cmp_meta_reg <= overcurrent_cmp;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// the turn-on cycle itself is blanked, the timer covers the rest of the window
	assign blanking = pwm_on_edge | (blank_cnt_reg != {`FOB_CNT_W{1'b0}});

	// a sample counts toward debounce only when it is high and outside the blanking window
	assign cmp_live = cmp_sync_reg & ~blanking;

	// the count saturates one short of the programmed length, so the next live sample trips
	assign deb_full = (deb_cnt_reg == deb_cycles - CNT_ONE);

	// a trip needs deb_cycles consecutive unblanked high samples
	assign trip = cmp_live & deb_full;

	// blanking timer: reloads on every turn-on edge, otherwise runs down to zero and stops
	always @*
	begin
		blank_cnt_next = blank_cnt_reg;
		if (pwm_on_edge)
			blank_cnt_next = blank_cycles - CNT_ONE;
		else if (blank_cnt_reg != CNT_ZERO)
			blank_cnt_next = blank_cnt_reg - CNT_ONE;
	end

	// debounce counter: saturates at the trip point; a dip or a blanked cycle starts over
	always @*
	begin
		deb_cnt_next = deb_cnt_reg;
		if (!cmp_live)
			deb_cnt_next = CNT_ZERO;
		else if (!deb_full)
			deb_cnt_next = deb_cnt_reg + CNT_ONE;
	end

	// cutoff flag: a new switching cycle releases it, but a trip in that same cycle wins
	always @*
	begin
		shutdown_next = overcurrent_shutdown;
		if (cycle_start)
			shutdown_next = 1'b0;
		if (trip)
			shutdown_next = 1'b1;
	end

	// timer and counter state
	always @(posedge clock)
	begin
		if (srst)
		begin
			blank_cnt_reg <= CNT_ZERO;
			deb_cnt_reg   <= CNT_ZERO;
		end
		else
		begin
			blank_cnt_reg <= blank_cnt_next;
			deb_cnt_reg   <= deb_cnt_next;
		end
	end

	// cutoff level, trip pulse and gated pwm; gating uses the next cutoff value so the
	// outputs go off with the trip rather than one cycle after it
	always @(posedge clock)
	begin
		if (srst)
		begin
			overcurrent_shutdown <= 1'b0;
			overcurrent_event    <= 1'b0;
			pwm_out              <= {PWM_N{1'b0}};
		end
		else
		begin
			overcurrent_shutdown <= shutdown_next;
			overcurrent_event    <= trip;
			pwm_out              <= shutdown_next ? {PWM_N{1'b0}} : pwm_in;
		end
	end

	// threshold code goes out to the analog comparator as level and polarity; polarity is
	// not applied here, the comparator output is taken as already oriented
	always @(posedge clock)
	begin
		if (srst)
		begin
			limit_level    <= 2'h0;
			limit_negative <= 1'b0;
		end
		else
		begin
			limit_level    <= current_limit_threshold[`FOB_LIM_LEVEL_HI:`FOB_LIM_LEVEL_LO];
			limit_negative <= current_limit_threshold[`FOB_LIM_NEG];
		end
	end

endmodule

// ---- test/fob_top_sva.sv ----
// checker for the fast overcurrent blanking top: trip, cutoff, blanking, register reads
// assumes one clock and the synchronous active high reset of the design
`timescale 1ns/1ps
module fob_chk #(
	parameter PWM_N = 2
) (
	input logic             clock,
	input logic             srst,
	input logic [15:0]      reg_addr,
	input logic             reg_wr_en,
	input logic             reg_rd_en,
	input logic [15:0]      reg_rdata,
	input logic             overcurrent_cmp,
	input logic [2:0]       current_limit_threshold,
	input logic [PWM_N-1:0] pwm_in,
	input logic             pwm_on_edge,
	input logic             cycle_start,
	input logic [PWM_N-1:0] pwm_out,
	input logic [1:0]       limit_level,
	input logic             limit_negative,
	input logic             overcurrent_event,
	input logic             overcurrent_shutdown,
	input logic [15:0]      input_current_gain_scale
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// the synchroniser puts the last high sample three edges before the trip shows
	a_trip_cause: assert property ($rose(overcurrent_shutdown) |-> $past(overcurrent_cmp, 3))
		else $error("trip without high comparator");
	a_blank_quiet: assert property (pwm_on_edge |=> !overcurrent_event)
		else $error("trip inside blanking");
	a_cut_pwm: assert property (overcurrent_shutdown |-> pwm_out == '0)
		else $error("pwm active while cut off");
	a_pwm_follow: assert property (!overcurrent_shutdown && !$past(srst) |-> pwm_out == $past(pwm_in))
		else $error("pwm does not follow input");
	a_shut_hold: assert property (overcurrent_shutdown && !cycle_start |=> overcurrent_shutdown)
		else $error("cutoff ended before cycle end");
	a_shut_release: assert property (cycle_start |=> !overcurrent_shutdown || overcurrent_event)
		else $error("cutoff kept past cycle end");
	a_event_shut: assert property (overcurrent_event |-> overcurrent_shutdown)
		else $error("trip pulse without cutoff");
	a_limit_copy: assert property (!$past(srst) |-> {limit_negative, limit_level} == $past(current_limit_threshold))
		else $error("threshold not passed on");
	a_gain_read: assert property (reg_rd_en && !reg_wr_en && reg_addr == 16'hfe3c
		|=> reg_rdata == input_current_gain_scale && !reg_rdata[10])
		else $error("gain read wrong");
	a_timing_rsvd: assert property (reg_rd_en && reg_addr == 16'hfe3d |=> reg_rdata[15:5] == 11'h000)
		else $error("timing reserved bits set");
endmodule
bind fob_top fob_chk #(.PWM_N(PWM_N)) u_chk (.*);

// ---- test/tb.sv ----
// self-checking bench for the fast overcurrent blanking top
// assumes a 20 MHz clock and the one-cycle register read of the design
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic        reg_wr_en = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_rd_en = 1'b0;
	logic [15:0] reg_rdata, input_current_gain_scale;
	logic        overcurrent_cmp = 1'b0;
	logic [2:0]  current_limit_threshold = 3'h6;
	logic [1:0]  pwm_in = 2'h3;
	logic        pwm_on_edge = 1'b0;
	logic        cycle_start = 1'b0;
	logic [1:0]  pwm_out, limit_level;
	logic        limit_negative, overcurrent_event, overcurrent_shutdown;
	int          bad_count = 0;
	int          checks = 0;
	int          dcyc[4] = '{1, 2, 3, 5};
	int          bcyc[8] = '{1, 2, 3, 4, 4, 8, 12, 16};
	// 50 ns period
	always #25 clock = ~clock;
	fob_top dut (.*);
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clock);
		reg_wr_en <= 1'b0;
	endtask
	task rdc(input logic [15:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clock);
		reg_rd_en <= 1'b0;
		@(posedge clock);
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	// edges until the trip pulse; bounded, a missing pulse ends the run
	task trip_after(output int n);
		n = 0;
		while (n < 41 && overcurrent_event !== 1'b1)
		begin
			@(posedge clock);
			#1 n++;
		end
		if (overcurrent_event !== 1'b1)
		begin
			bad_count++;
			$display("[FAIL] trip_wait expected event seen none");
			stop_test;
		end
	endtask
	// drop the comparator and end the cycle; pwm must come back and follow its input
	task clear;
		@(posedge clock);
		overcurrent_cmp <= 1'b0;
		tick(4);
		cycle_start <= 1'b1;
		@(posedge clock);
		cycle_start <= 1'b0;
		tick(2);
		#1 chk("pwm_out", 16'h3, {14'h0, pwm_out});
		@(posedge clock);
		pwm_in <= 2'h1;
		@(posedge clock);
		pwm_in <= 2'h3;
		#1 chk("pwm_follow", 16'h1, {14'h0, pwm_out});
	endtask
	task t_regs;
		rdc(16'hfe3c, 16'h0000);
		rdc(16'hfe3d, 16'h0000);
		wr(16'hfe3c, 16'hffff);
		rdc(16'hfe3c, 16'hfbff);
		chk("gain", 16'hfbff, input_current_gain_scale);
		wr(16'hfe3c, 16'h8155);
		rdc(16'hfe3c, 16'h8155);
		wr(16'hfe3d, 16'hffff);
		rdc(16'hfe3d, 16'h001f);
		rdc(16'hfe3e, 16'h0000);
		chk("limit", 16'h6, {13'h0, limit_negative, limit_level});
		@(posedge clock);
		current_limit_threshold <= 3'h3;
		tick(2);
		#1 chk("limit", 16'h3, {13'h0, limit_negative, limit_level});
	endtask
	// a pulse one cycle short of the debounce must not trip; a steady one trips on time
	task t_debounce;
		int n;
		for (int d = 0; d < 4; d++)
		begin
			wr(16'hfe3d, 16'(d << 3));
			@(posedge clock);
			// a one-cycle debounce has no shorter pulse to try
			if (dcyc[d] > 1)
			begin
				overcurrent_cmp <= 1'b1;
				tick(dcyc[d] - 1);
				overcurrent_cmp <= 1'b0;
			end
			tick(8);
			#1 chk("overcurrent_shutdown", 16'h0, {15'h0, overcurrent_shutdown});
			@(posedge clock);
			overcurrent_cmp <= 1'b1;
			trip_after(n);
			chk("trip_edges", 16'(dcyc[d] + 2), 16'(n));
			chk("pwm_cut", 16'h0, {14'h0, pwm_out});
			clear;
		end
	endtask
	// comparator high from the turn-on edge: the trip waits out the blanking; odd codes also
	// take the two-cycle debounce, which must not count while blanked
	task t_blank;
		int n;
		for (int b = 0; b < 8; b++)
		begin
			wr(16'hfe3d, 16'(b | ((b & 1) << 3)));
			@(posedge clock);
			pwm_on_edge <= 1'b1;
			overcurrent_cmp <= 1'b1;
			@(posedge clock);
			pwm_on_edge <= 1'b0;
			trip_after(n);
			chk("blank_edges", 16'((bcyc[b] > 2 ? bcyc[b] : 2) + dcyc[b & 1] - 1), 16'(n));
			clear;
		end
	endtask
	initial
	begin
		tick(4);
		srst <= 1'b0;
		t_regs;
		t_debounce;
		t_blank;
		stop_test;
	end
endmodule
